// ==== rtl/error_status_flag_bank.sv ====
// Sticky error-status flag bank: throttle bins, input-pin and fan flags.
//
// What this block does
// - Any nonzero throttling sets bit 0.
// - Processor one bit 1 for 0.39 to 12.5 percent.
// - Processor two bit 1 lower bound is configurable.
// - Bits 2 to 5 follow the duty bins.
// - Full throttle duty sets bit 6.
// - Duty above user limit sets bit 7.
// - Only throttle bit 7, pin and fan flags feed management summary flag.
// - Unmasked low general pin sets its flag.
// - Fan over tach limit sets flag; 7:4 reserved.
// - Events set bits; any pin, fan or throttle bit 7 sets host summary.
// - Fixed throttle bins excluded from host summary.
// - Flags stay set until software clears them.
// - Clear fails while condition still present.
// - Write one clears; write zero keeps bit.
// - Sleep state suppresses listed events.
// - Optional sleep masking obeys sleep mask bits.
// - Throttle events masked in S3 and S4/5.
// - Input and fan optional masks; fan S4/5 always.
`timescale 1ns/10ps
`default_nettype none

module error_status_flag_bank #(
    parameter int         TACH_WIDTH      = 8,
    parameter logic [8:0] P2_LOW_MIN      = err_flag_pkg::DUTY_P2_LOW_MIN
) (
    input  wire logic                            mclk,
    input  wire logic                            rstn,
    input  wire logic                            clk_en,
    input  wire logic [7:0]                      reg_addr,
    input  wire logic                            reg_wr,
    input  wire logic                            reg_rd,
    input  wire logic [7:0]                      reg_wdata,
    output logic      [7:0]                      reg_rdata,
    input  wire logic                            cpu_one_throttle_input,
    input  wire logic                            cpu_two_throttle_input,
    input  wire logic                            duty_valid,
    input  wire logic [8:0]                      cpu_one_duty,
    input  wire logic [8:0]                      cpu_two_duty,
    input  wire logic [8:0]                      cpu_one_limit,
    input  wire logic [8:0]                      cpu_two_limit,
    input  wire logic [7:0]                      general_pin,
    input  wire logic [7:0]                      input_error_mask,
    input  wire logic [err_flag_pkg::FAN_COUNT*TACH_WIDTH-1:0] fan_tach,
    input  wire logic [err_flag_pkg::FAN_COUNT*TACH_WIDTH-1:0] fan_tach_limit,
    input  wire logic [1:0]                      sleep_state,
    input  wire logic [2:0]                      input_sleep_mask,
    input  wire logic [1:0]                      fan_sleep_mask,
    output logic                                 mgmt_summary_flag,
    output logic                                 host_summary_flag
);

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
        reg_hit = (addr == off);
    endfunction : reg_hit

    // Returns the eight throttle events for one duty sample.
    function automatic logic [7:0] throttle_events(
        input logic [8:0] duty,
        input logic [8:0] low_min,
        input logic [8:0] limit,
        input logic       live
    );
        logic [7:0] ev;
        ev = 8'h00;
        ev[err_flag_pkg::BIT_ANY]    = live || (duty != 9'h000);
        ev[err_flag_pkg::BIT_LOWEST] = (duty >= low_min) && (duty < err_flag_pkg::DUTY_12P5);
        ev[err_flag_pkg::BIT_SECOND] = (duty >= err_flag_pkg::DUTY_12P5)
                                    && (duty < err_flag_pkg::DUTY_25);
        ev[err_flag_pkg::BIT_THIRD]  = (duty >= err_flag_pkg::DUTY_25)
                                    && (duty < err_flag_pkg::DUTY_50);
        ev[err_flag_pkg::BIT_FOURTH] = (duty >= err_flag_pkg::DUTY_50)
                                    && (duty < err_flag_pkg::DUTY_75);
        ev[err_flag_pkg::BIT_FIFTH]  = (duty >= err_flag_pkg::DUTY_75)
                                    && (duty < err_flag_pkg::DUTY_FULL);
        ev[err_flag_pkg::BIT_FULL]   = (duty >= err_flag_pkg::DUTY_FULL);
        ev[err_flag_pkg::BIT_LIMIT]  = (duty > limit);
        throttle_events = ev;
    endfunction : throttle_events

    // Masking decision for one event class: always-masked states and
    // optional states whose mask bit software has set.
    function automatic logic sleep_blocks(
        input logic [1:0] state,
        input logic [2:0] always_s1_s3_s45,
        input logic [2:0] opt_s1_s3_s45,
        input logic [2:0] req_s1_s3_s45
    );
        logic [2:0] gate;
        gate = always_s1_s3_s45 | (opt_s1_s3_s45 & req_s1_s3_s45);
        case (state)
            err_flag_pkg::SLEEP_S1:  sleep_blocks = gate[0];
            err_flag_pkg::SLEEP_S3:  sleep_blocks = gate[1];
            err_flag_pkg::SLEEP_S45: sleep_blocks = gate[2];
            default:                 sleep_blocks = 1'b0;
        endcase
    endfunction : sleep_blocks

    // ------------------------------------------------------------------
    // Event sources
    // ------------------------------------------------------------------
    logic       throttle_masked;
    logic       input_masked;
    logic       fan_masked;
    logic [7:0] p1_ev;
    logic [7:0] p2_ev;
    logic [7:0] pin_ev;
    logic [7:0] fan_ev;
    logic [3:0] fan_over;

    // Live throttle pins count only as nonzero throttling; bins need a sample.
    assign p1_ev = duty_valid
        ? throttle_events(cpu_one_duty, err_flag_pkg::DUTY_P1_LOW_MIN,
                          cpu_one_limit, cpu_one_throttle_input)
        : {7'h00, cpu_one_throttle_input};
    assign p2_ev = duty_valid
        ? throttle_events(cpu_two_duty, P2_LOW_MIN,
                          cpu_two_limit, cpu_two_throttle_input)
        : {7'h00, cpu_two_throttle_input};

    assign throttle_masked = sleep_blocks(sleep_state, 3'b110, 3'b000, 3'b000);
    assign input_masked    = sleep_blocks(sleep_state, 3'b000, 3'b111,
                                          input_sleep_mask);
    assign fan_masked      = sleep_blocks(sleep_state, 3'b100, 3'b011,
                                          {1'b0, fan_sleep_mask});

    assign pin_ev = ~general_pin & ~input_error_mask;

    genvar fi;
    generate
        for (fi = 0; fi < err_flag_pkg::FAN_COUNT; fi++) begin : g_fan
            assign fan_over[fi] = fan_tach[fi*TACH_WIDTH +: TACH_WIDTH]
                                > fan_tach_limit[fi*TACH_WIDTH +: TACH_WIDTH];
        end
    endgenerate
    assign fan_ev = {4'h0, fan_over};

    // ------------------------------------------------------------------
    // Write-one-to-clear strobes
    // ------------------------------------------------------------------
    logic [7:0] clr_p1;
    logic [7:0] clr_p2;
    logic [7:0] clr_pin;
    logic [7:0] clr_fan;

    assign clr_p1  = (reg_wr && reg_hit(reg_addr, err_flag_pkg::OFF_PROC1_THROTTLE))
                   ? reg_wdata : 8'h00;
    assign clr_p2  = (reg_wr && reg_hit(reg_addr, err_flag_pkg::OFF_PROC2_THROTTLE))
                   ? reg_wdata : 8'h00;
    assign clr_pin = (reg_wr && reg_hit(reg_addr, err_flag_pkg::OFF_INPUT_PIN_ERR))
                   ? reg_wdata : 8'h00;
    assign clr_fan = (reg_wr && reg_hit(reg_addr, err_flag_pkg::OFF_FAN_SPEED_ERR))
                   ? reg_wdata : 8'h00;

    // ------------------------------------------------------------------
    // Sticky flags
    // ------------------------------------------------------------------
    // A set arriving with a clear wins, so a persisting condition cannot be
    // cleared and a fresh event is never lost.
    logic [7:0] p1_q;
    logic [7:0] p2_q;
    logic [7:0] pin_q;
    logic [7:0] fan_q;
    logic [7:0] p1_d;
    logic [7:0] p2_d;
    logic [7:0] pin_d;
    logic [7:0] fan_d;

    assign p1_d  = (p1_q & ~clr_p1) | (throttle_masked ? 8'h00 : p1_ev);
    assign p2_d  = (p2_q & ~clr_p2) | (throttle_masked ? 8'h00 : p2_ev);
    assign pin_d = (pin_q & ~clr_pin) | (input_masked ? 8'h00 : pin_ev);
    assign fan_d = ((fan_q & ~clr_fan) | (fan_masked ? 8'h00 : fan_ev))
                 & err_flag_pkg::FAN_VALID_MASK;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            p1_q  <= err_flag_pkg::RST_STATUS;
            p2_q  <= err_flag_pkg::RST_STATUS;
            pin_q <= err_flag_pkg::RST_STATUS;
            fan_q <= err_flag_pkg::RST_STATUS;
        end else if (clk_en) begin
            p1_q  <= p1_d;
            p2_q  <= p2_d;
            pin_q <= pin_d;
            fan_q <= fan_d;
        end
    end

    // ------------------------------------------------------------------
    // Summary flags
    // ------------------------------------------------------------------
    // Only the user-limit bits of the throttle registers reach the summaries.
    logic summary_d;

    assign summary_d = p1_d[err_flag_pkg::BIT_LIMIT] | p2_d[err_flag_pkg::BIT_LIMIT]
                     | (|pin_d) | (|fan_d);

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            mgmt_summary_flag <= 1'b0;
            host_summary_flag <= 1'b0;
        end else if (clk_en) begin
            mgmt_summary_flag <= summary_d;
            host_summary_flag <= summary_d;
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    // Read data is registered: it appears the edge after reg_rd and holds.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (clk_en && reg_rd) begin
            case (reg_addr)
                err_flag_pkg::OFF_PROC1_THROTTLE: reg_rdata <= p1_q;
                err_flag_pkg::OFF_PROC2_THROTTLE: reg_rdata <= p2_q;
                err_flag_pkg::OFF_INPUT_PIN_ERR:  reg_rdata <= pin_q;
                err_flag_pkg::OFF_FAN_SPEED_ERR:  reg_rdata <= fan_q;
                default:                          reg_rdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_clear_p1_limit;
        clk_en && clr_p1[err_flag_pkg::BIT_LIMIT];
    endsequence

    sequence s_limit_event_p1;
        clk_en && duty_valid && !throttle_masked && (cpu_one_duty > cpu_one_limit);
    endsequence

    property p_any_throttle;
        @(posedge mclk) disable iff (!rstn)
        (clk_en && cpu_one_throttle_input && !throttle_masked) |=> p1_q[0];
    endproperty
    a_any_throttle: assert property (p_any_throttle) else $error("any-throttle flag not set");

    property p_p1_lowest;
        @(posedge mclk) disable iff (!rstn)
        (clk_en && duty_valid && !throttle_masked && cpu_one_duty == 9'h001) |=> p1_q[1];
    endproperty
    a_p1_lowest: assert property (p_p1_lowest) else $error("lowest bin not set");

    property p_bins;
        @(posedge mclk) disable iff (!rstn)
        (clk_en && duty_valid && !throttle_masked && cpu_two_duty == 9'h0C0)
            |=> p2_q[5] && (p2_q[4] == $past(p2_q[4] & ~clr_p2[4]));
    endproperty
    a_bins: assert property (p_bins) else $error("fourth bin wrong");

    property p_full;
        @(posedge mclk) disable iff (!rstn)
        (clk_en && duty_valid && !throttle_masked && cpu_one_duty == 9'h100) |=> p1_q[6];
    endproperty
    a_full: assert property (p_full) else $error("full flag not set");

    property p_limit_wins;
        @(posedge mclk) disable iff (!rstn)
        (s_limit_event_p1 and s_clear_p1_limit) |=> p1_q[7] && mgmt_summary_flag;
    endproperty
    a_limit_wins: assert property (p_limit_wins) else $error("clear beat a live event");

    property p_bins_no_summary;
        @(posedge mclk) disable iff (!rstn)
        (clk_en && !p1_d[err_flag_pkg::BIT_LIMIT] && !p2_d[err_flag_pkg::BIT_LIMIT]
            && pin_d == 8'h00 && fan_d == 8'h00)
            |=> !host_summary_flag && !mgmt_summary_flag;
    endproperty
    a_bins_no_summary: assert property (p_bins_no_summary) else $error("bin fed summary");

    property p_sticky;
        @(posedge mclk) disable iff (!rstn)
        (clk_en && pin_q[0] && !clr_pin[0]) |=> pin_q[0];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped by itself");

    property p_w1c;
        @(posedge mclk) disable iff (!rstn)
        (clk_en && clr_pin[3] && !(pin_ev[3] && !input_masked)) |=> !pin_q[3];
    endproperty
    a_w1c: assert property (p_w1c) else $error("write one did not clear");

    property p_sleep_throttle;
        @(posedge mclk) disable iff (!rstn)
        (clk_en && sleep_state == err_flag_pkg::SLEEP_S3 && !p1_q[0] && !clr_p1[0])
            |=> !p1_q[0];
    endproperty
    a_sleep_throttle: assert property (p_sleep_throttle) else $error("event not masked in S3");

    property p_fan_reserved;
        @(posedge mclk) disable iff (!rstn)
        fan_q[7:4] == 4'h0;
    endproperty
    a_fan_reserved: assert property (p_fan_reserved) else $error("reserved fan bit set");

endmodule : error_status_flag_bank

`default_nettype wire

// ==== rtl/err_flag_pkg.sv ====
// Constants shared by the sticky error-status flag bank.
package err_flag_pkg;

    // ------------------------------------------------------------------
    // Register offsets and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_PROC1_THROTTLE = 8'h44;
    localparam logic [7:0] OFF_PROC2_THROTTLE = 8'h45;
    localparam logic [7:0] OFF_INPUT_PIN_ERR  = 8'h46;
    localparam logic [7:0] OFF_FAN_SPEED_ERR  = 8'h47;
    localparam logic [7:0] RST_STATUS         = 8'h00;

    // ------------------------------------------------------------------
    // Throttle status field positions and fan flag layout
    // ------------------------------------------------------------------
    localparam int BIT_ANY    = 0;
    localparam int BIT_LOWEST = 1;
    localparam int BIT_SECOND = 2;
    localparam int BIT_THIRD  = 3;
    localparam int BIT_FOURTH = 4;
    localparam int BIT_FIFTH  = 5;
    localparam int BIT_FULL   = 6;
    localparam int BIT_LIMIT  = 7;
    localparam int FAN_COUNT  = 4;
    localparam logic [7:0] FAN_VALID_MASK = 8'h0F;

    // ------------------------------------------------------------------
    // Duty thresholds in 1/256 steps; 256 is full throttle
    // ------------------------------------------------------------------
    localparam logic [8:0] DUTY_P1_LOW_MIN = 9'h001;
    localparam logic [8:0] DUTY_P2_LOW_MIN = 9'h000;
    localparam logic [8:0] DUTY_12P5       = 9'h020;
    localparam logic [8:0] DUTY_25         = 9'h040;
    localparam logic [8:0] DUTY_50         = 9'h080;
    localparam logic [8:0] DUTY_75         = 9'h0C0;
    localparam logic [8:0] DUTY_FULL       = 9'h100;

    // ------------------------------------------------------------------
    // Sleep states as written by software into the sleep control register
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SLEEP_S0  = 2'b00,
        SLEEP_S1  = 2'b01,
        SLEEP_S3  = 2'b10,
        SLEEP_S45 = 2'b11
    } sleep_type;

endpackage : err_flag_pkg

// ==== tb/host_model.sv ====
// Host-side register access model for the error-status flag bank.
`timescale 1ns/10ps
`default_nettype none

module host_model (
    input  wire logic       mclk,
    output logic [7:0]      reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata,
    output logic [1:0]      sleep_state
);
    initial begin
        reg_addr    = 8'h00;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        reg_wdata   = 8'h00;
        sleep_state = 2'h0;
    end

    // --------------------------------------------------------------
    // Bus cycles
    // --------------------------------------------------------------
    // An idle bus shows inverted values so a stale address is never trusted.
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge mclk);
        #1;
        reg_addr  = addr;
        reg_wdata = data;
        reg_wr    = 1'b1;
        @(posedge mclk);
        #1;
        reg_wr    = 1'b0;
        reg_addr  = ~addr;
        reg_wdata = ~data;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge mclk);
        #1;
        reg_addr = addr;
        reg_rd   = 1'b1;
        @(posedge mclk);
        #1;
        reg_rd   = 1'b0;
        reg_addr = ~addr;
        data     = reg_rdata;
    endtask : read_reg

    task automatic set_sleep(input logic [1:0] state);
        @(posedge mclk);
        #1;
        sleep_state = state;
    endtask : set_sleep
endmodule : host_model

`default_nettype wire

// ==== tb/error_status_flag_bank_bench.sv ====
// Self-checking bench for the sticky error-status flag bank.
`timescale 1ns/10ps
`default_nettype none

module error_status_flag_bank_bench;
    logic        mclk, rstn, clk_en, duty_valid, thr1, thr2, mgmt, host;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, general_pin, in_mask, rd;
    logic        reg_wr, reg_rd;
    logic [1:0]  sleep_state, fan_sleep_mask;
    logic [2:0]  input_sleep_mask;
    logic [8:0]  duty1, duty2, lim1, lim2;
    logic [31:0] fan_tach;
    int          n_errors, n_tests, cycles;
    logic [8:0]  dv [10] = '{9'h000, 9'h001, 9'h01F, 9'h020, 9'h040,
                             9'h07F, 9'h080, 9'h0C0, 9'h0FF, 9'h100};
    logic [7:0]  e1 [10] = '{8'h00, 8'h03, 8'h03, 8'h05, 8'h09,
                             8'h09, 8'h11, 8'h21, 8'h21, 8'h41};

    error_status_flag_bank dut (
        .mclk(mclk), .rstn(rstn), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .cpu_one_throttle_input(thr1), .cpu_two_throttle_input(thr2),
        .duty_valid(duty_valid), .cpu_one_duty(duty1), .cpu_two_duty(duty2),
        .cpu_one_limit(lim1), .cpu_two_limit(lim2), .general_pin(general_pin),
        .input_error_mask(in_mask), .fan_tach(fan_tach), .fan_tach_limit({4{8'h80}}),
        .sleep_state(sleep_state), .input_sleep_mask(input_sleep_mask),
        .fan_sleep_mask(fan_sleep_mask), .mgmt_summary_flag(mgmt), .host_summary_flag(host));

    host_model hm (
        .mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sleep_state(sleep_state));

    // --------------------------------------------------------------
    // Compare and closing tasks
    // --------------------------------------------------------------
    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check8

    task automatic check1(input logic got, input logic exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s flag got %b expected %b", $time, what, got, exp);
        end
    endtask : check1

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    // --------------------------------------------------------------
    // Stimulus helpers
    // --------------------------------------------------------------
    // Events last one cycle, so any later clear sees the condition gone.
    task automatic ev(input logic v, input logic t, input logic [8:0] d,
                      input logic [7:0] pins, input logic [31:0] tach);
        @(posedge mclk);
        #1;
        duty_valid  = v;
        thr1        = t;
        thr2        = t;
        duty1       = d;
        duty2       = d;
        general_pin = pins;
        fan_tach    = tach;
        @(posedge mclk);
        #1;
        duty_valid  = 1'b0;
        thr1        = 1'b0;
        thr2        = 1'b0;
        general_pin = 8'hFF;
        fan_tach    = 32'h0;
    endtask : ev

    task automatic expect_reg(input logic [7:0] addr, input logic [7:0] exp);
        hm.read_reg(addr, rd);
        check8(rd, exp, "register");
    endtask : expect_reg

    task automatic clear_all;
        for (int a = 0; a < 4; a++) begin
            hm.write_reg(8'h44 + 8'(a), 8'hFF);
        end
    endtask : clear_all

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 6000) begin
            n_errors++;
            final_report();
        end
    end

    initial begin
        rstn = 1'b0; duty_valid = 1'b0; thr1 = 1'b0; thr2 = 1'b0;
        clk_en = 1'b1;
        duty1 = 9'h0; duty2 = 9'h0; lim1 = 9'h1FF; lim2 = 9'h1FF;
        general_pin = 8'hFF; in_mask = 8'h00; fan_tach = 32'h0;
        input_sleep_mask = 3'h0; fan_sleep_mask = 2'h0;
        repeat (5) @(posedge mclk);
        #1;
        rstn = 1'b1;
        for (int a = 0; a < 4; a++) expect_reg(8'h44 + 8'(a), 8'h00);
        expect_reg(8'h50, 8'h00);
        $display("reset values done");
        ev(1'b0, 1'b1, 9'h0, 8'hFF, 32'h0);
        expect_reg(8'h44, 8'h01);
        expect_reg(8'h45, 8'h01);
        clear_all();
        for (int i = 0; i < 10; i++) begin
            ev(1'b1, 1'b0, dv[i], 8'hFF, 32'h0);
            check1(host, 1'b0, "bins host");
            check1(mgmt, 1'b0, "bins mgmt");
            expect_reg(8'h44, e1[i]);
            expect_reg(8'h45, (i == 0) ? 8'h02 : e1[i]);
            clear_all();
        end
        $display("duty bins done");
        lim1 = 9'h080;
        lim2 = 9'h081;
        ev(1'b1, 1'b0, 9'h081, 8'hFF, 32'h0);
        check1(mgmt, 1'b1, "limit mgmt");
        expect_reg(8'h44, 8'h91);
        expect_reg(8'h45, 8'h11);
        clear_all();
        // A clear landing on the same edge as a live limit event must lose.
        fork
            ev(1'b1, 1'b0, 9'h081, 8'hFF, 32'h0);
            hm.write_reg(8'h44, 8'hFF);
        join
        check1(mgmt, 1'b1, "clash mgmt");
        expect_reg(8'h44, 8'h91);
        clear_all();
        lim1 = 9'h1FF;
        lim2 = 9'h1FF;
        $display("user limit done");
        in_mask = 8'h02;
        general_pin = 8'hFC;
        hm.write_reg(8'h46, 8'hFF);
        expect_reg(8'h46, 8'h01);
        general_pin = 8'hFF;
        expect_reg(8'h46, 8'h01);
        check1(host, 1'b1, "pin host");
        hm.write_reg(8'h46, 8'h00);
        expect_reg(8'h46, 8'h01);
        hm.write_reg(8'h46, 8'h01);
        expect_reg(8'h46, 8'h00);
        check1(host, 1'b0, "clear host");
        in_mask = 8'h00;
        $display("sticky clear done");
        ev(1'b0, 1'b0, 9'h0, 8'hFF, 32'hFF008081);
        hm.write_reg(8'h47, 8'hF0);
        expect_reg(8'h47, 8'h09);
        clear_all();
        expect_reg(8'h47, 8'h00);
        $display("fan flags done");
        ev(1'b0, 1'b1, 9'h0, 8'hFE, 32'h0);
        // While the enable is low neither clears nor new events may land.
        clk_en = 1'b0;
        hm.write_reg(8'h44, 8'hFF);
        ev(1'b0, 1'b0, 9'h0, 8'h00, 32'h0);
        clk_en = 1'b1;
        expect_reg(8'h44, 8'h01);
        expect_reg(8'h46, 8'h01);
        check1(host, 1'b1, "frozen host");
        rstn = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        rstn = 1'b1;
        expect_reg(8'h44, 8'h00);
        expect_reg(8'h46, 8'h00);
        check1(host, 1'b0, "reset host");
        $display("freeze and reset done");
        for (int s = 0; s < 4; s++) begin
            for (int m = 0; m < 2; m++) begin
                input_sleep_mask = (m == 1) ? 3'h7 : 3'h0;
                fan_sleep_mask = (m == 1) ? 2'h3 : 2'h0;
                hm.set_sleep(2'(s));
                ev(1'b1, 1'b0, 9'h100, 8'hFE, 32'h81);
                expect_reg(8'h44, (s >= 2) ? 8'h00 : 8'h41);
                expect_reg(8'h46, (s != 0 && m == 1) ? 8'h00 : 8'h01);
                expect_reg(8'h47, (s == 3 || (s != 0 && m == 1)) ? 8'h00 : 8'h01);
                hm.set_sleep(2'h0);
                clear_all();
            end
        end
        $display("sleep masking done");
        final_report();
    end
endmodule : error_status_flag_bank_bench

`default_nettype wire
